// *** rtl/bpcfg_pkg.sv ***
// Package for the backport configuration and clocking block.
// Assumes one 40 MHz system clock and a plain register port.
package bpcfg_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] BPCFG_OFF_MODE   = 8'h00;
    localparam logic [7:0] BPCFG_OFF_STATUS = 8'h04;
    localparam logic [7:0] BPCFG_OFF_IRQF   = 8'h08;
    localparam logic [7:0] BPCFG_OFF_HBREG  = 8'h0C;
    localparam logic [7:0] BPCFG_OFF_SA_LO  = 8'h10;
    localparam logic [7:0] BPCFG_OFF_SA_MID = 8'h14;
    localparam logic [7:0] BPCFG_OFF_SA_HI  = 8'h18;
    // Field positions
    localparam int BPCFG_MODE_LEGACY_BIT  = 0;
    localparam int BPCFG_STAT_NETOPS_BIT  = 0;
    localparam int BPCFG_STAT_RBOOT_BIT   = 1;
    localparam int BPCFG_STAT_SANITY_BIT  = 2;
    localparam int BPCFG_STAT_LEGACY_BIT  = 3;
    localparam int BPCFG_STAT_UNIT2_BIT   = 4;
    // Host base addresses, octal 17774440 and 17774460
    localparam logic [21:0] BPCFG_BASE_UNIT1 = 22'h3F_F920;
    localparam logic [21:0] BPCFG_BASE_UNIT2 = 22'h3F_F930;
    // Station address default, arbitrary value
    localparam logic [47:0] BPCFG_SA_DEFAULT = 48'h0200_0000_0001;
    // Clock figures
    localparam int BPCFG_OSC_MHZ  = 40;
    localparam int BPCFG_HALF_MHZ = 20;
    localparam int BPCFG_PROC_MHZ = 10;
    localparam int BPCFG_PROC_DIV = BPCFG_OSC_MHZ / BPCFG_PROC_MHZ;
    // Requester indices
    localparam int BPCFG_REQ_PROC = 0;
    localparam int BPCFG_REQ_LAN  = 1;
    localparam int BPCFG_REQ_HBI  = 2;
    // Arbiter states
    typedef enum logic [3:0] {
        BPCFG_IDLE  = 4'b0001,
        BPCFG_GPROC = 4'b0010,
        BPCFG_GLAN  = 4'b0100,
        BPCFG_GHBI  = 4'b1000
    } bpcfg_arb_e;
    // Switch straps carried together
    typedef struct packed {
        logic base_open;
        logic mode_open;
        logic option_open;
    } bpcfg_straps_s;
    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bpcfg_reg_req_s;
endpackage

// *** rtl/bpcfg_top.sv ***
// Backport configuration, clocking and arbitration block.
// Assumes straps are asynchronous pins; requesters hold req until done.
// Assumes register strobes last one cycle and never come together.
// How it works
// - Base address strap picks unit address
// - Closed mode switch: normal, software selectable
// - Normal mode: net ops, boot if open
// - Open mode switch: legacy, no net ops
// - Legacy: auto sanity only if option open
// - Divide oscillator into antiphase half rates
// - Other phase yields 10MHz LAN clock
// - Divider makes 10MHz processor clock
// - Arbitrate processor, LAN, host interface
// - Arbiter drives strobes, holds control regs
// - Only processor may reach firmware ROM
// - Read-only 48-bit station address store
// - One direction control, address/data transceivers
// - Separate direction control, DMA control transceiver
// - Host slave access to I/O registers
// - Control and data DMA, block mode
// - Backport DMA over 16 lines
// - Interface controller registers via backport
`timescale 1ns/1ps
module bpcfg_top
    import bpcfg_pkg::*;
(
    // Clock and reset
    input  wire logic          clock_i,
    input  wire logic          rst_n_i,
    // Switch straps, high means open
    input  wire bpcfg_straps_s straps_i,
    // Register port
    input  wire bpcfg_reg_req_s reg_req_i,
    output logic [31:0]        reg_rdata_o,
    // Backport requesters: proc, lan, host interface
    input  wire logic [2:0]    bp_req_i,
    input  wire logic [2:0]    bp_done_i,
    input  wire logic          bp_rom_sel_i,
    output logic [2:0]         bp_gnt_o,
    output logic               bp_rom_en_o,
    output logic               bp_strobe_o,
    // Host interface DMA requests
    input  wire logic          dma_ctrl_req_i,
    input  wire logic          dma_data_req_i,
    input  wire logic          host_slave_sel_i,
    input  wire logic          host_slave_rd_i,
    output logic               dma_ctrl_act_o,
    output logic               dma_data_act_o,
    output logic               dma_block_o,
    output logic               addr_data_xcvr_dir_o,
    output logic               ctrl_xcvr_dir_o,
    output logic [15:0]        bp_dma_addr_o,
    // Clocks and configuration
    output logic               clk_a_en_o,
    output logic               clk_b_en_o,
    output logic               lan_clk_o,
    output logic               proc_clk_o,
    output logic [21:0]        base_addr_o,
    output logic               net_ops_en_o,
    output logic               remote_boot_en_o,
    output logic               sanity_auto_o,
    output logic               legacy_compat_mode_o
);

    // Three-stage strap synchroniser
    bpcfg_straps_s sync1_reg;
    bpcfg_straps_s sync2_reg;
    bpcfg_straps_s sync3_reg;
    bpcfg_straps_s straps_reg;    // Filtered strap level
    logic          strap_seen_reg; // First agreement after reset

    // Mode state
    logic          legacy_sw_reg; // Software mode select
    logic          sanity_pu_reg; // Sanity auto latched at powerup

    // Divider state
    logic          phase_reg;     // 20 MHz phase toggle
    logic [1:0]    div_reg;       // Divider to 10 MHz

    // Arbiter state
    bpcfg_arb_e    arb_reg;
    bpcfg_arb_e    arb_next;
    logic [1:0]    last_reg;      // Last granted, for rotation

    // Host interface controller state
    logic [31:0]   hbreg_reg;     // Interface controller register
    logic [15:0]   dma_cnt_reg;   // Backport DMA address counter

    // Combined decode of mode from straps and software
    // Shared by mode outputs and status read so both agree
    function automatic logic is_legacy(input bpcfg_straps_s s, input logic sw);
        return s.mode_open | sw;
    endfunction

    // Synchroniser chain; stage one feeds only stage two
    // No reset: the chain refills from the pins anyway
    always_ff @(posedge clock_i) begin
        sync1_reg <= straps_i;
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
    end

    // Accept a strap change once stages two and three agree
    // A bouncing strap keeps its old level until settled
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            straps_reg     <= '0;
            strap_seen_reg <= 1'b0;
        end else if (sync2_reg == sync3_reg) begin
            straps_reg     <= sync3_reg;
            strap_seen_reg <= 1'b1;
        end
    end

    // Software mode bit, only writable when mode switch closed
    // Writes while the switch is open are dropped
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            legacy_sw_reg <= 1'b0;
        end else if (reg_req_i.wr && reg_req_i.addr == BPCFG_OFF_MODE) begin
            if (!straps_reg.mode_open) begin
                legacy_sw_reg <= reg_req_i.wdata[BPCFG_MODE_LEGACY_BIT];
            end
        end else if (straps_reg.mode_open) begin
            // Switch forces legacy; drop software choice
            legacy_sw_reg <= 1'b0;
        end
    end

    // Sanity auto-enable sampled once, at powerup
    // Later strap moves are ignored until the next reset
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sanity_pu_reg <= 1'b0;
        end else if (!strap_seen_reg && sync2_reg == sync3_reg) begin
            sanity_pu_reg <= sync3_reg.mode_open & sync3_reg.option_open;
        end
    end

    // Mode outputs and base address
    // These lag the filtered straps by one cycle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            base_addr_o          <= BPCFG_BASE_UNIT1;
            net_ops_en_o         <= 1'b0;
            remote_boot_en_o     <= 1'b0;
            sanity_auto_o        <= 1'b0;
            legacy_compat_mode_o <= 1'b0;
        end else begin
            base_addr_o <= straps_reg.base_open ? BPCFG_BASE_UNIT2 : BPCFG_BASE_UNIT1;
            legacy_compat_mode_o <= is_legacy(straps_reg, legacy_sw_reg);
            net_ops_en_o     <= !is_legacy(straps_reg, legacy_sw_reg);
            remote_boot_en_o <= !is_legacy(straps_reg, legacy_sw_reg)
                                & straps_reg.option_open;
            sanity_auto_o    <= sanity_pu_reg;
        end
    end

    // Clock divider: enables stand in for clocks in a single domain
    // Free running after reset; nothing else restarts it
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            phase_reg <= 1'b0;
            div_reg   <= '0;
        end else begin
            phase_reg <= ~phase_reg;
            div_reg   <= div_reg + 2'd1;
        end
    end

    // Enable outputs and derived clocks
    // Registered so derived clocks carry no decode glitch
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            clk_a_en_o <= 1'b0;
            clk_b_en_o <= 1'b0;
            lan_clk_o  <= 1'b0;
            proc_clk_o <= 1'b0;
        end else begin
            clk_a_en_o <= phase_reg;
            clk_b_en_o <= ~phase_reg;
            lan_clk_o  <= div_reg[1];
            proc_clk_o <= ~div_reg[1];
        end
    end

    // Arbiter next state; alternates host interface and LAN, processor only when neither of them is eligible
    // Skipping the last owner stops host interface or LAN starving the other; the processor can still starve
    always_comb begin
        arb_next = arb_reg;
        case (arb_reg)
            BPCFG_IDLE: begin
                if (bp_req_i[BPCFG_REQ_HBI] && last_reg != 2'd2) begin
                    arb_next = BPCFG_GHBI;
                end else if (bp_req_i[BPCFG_REQ_LAN] && last_reg != 2'd1) begin
                    arb_next = BPCFG_GLAN;
                end else if (bp_req_i[BPCFG_REQ_PROC]) begin
                    arb_next = BPCFG_GPROC;
                end else if (bp_req_i[BPCFG_REQ_HBI]) begin
                    arb_next = BPCFG_GHBI;
                end else if (bp_req_i[BPCFG_REQ_LAN]) begin
                    arb_next = BPCFG_GLAN;
                end
            end
            BPCFG_GPROC: if (bp_done_i[BPCFG_REQ_PROC]) arb_next = BPCFG_IDLE;
            BPCFG_GLAN:  if (bp_done_i[BPCFG_REQ_LAN])  arb_next = BPCFG_IDLE;
            BPCFG_GHBI:  if (bp_done_i[BPCFG_REQ_HBI])  arb_next = BPCFG_IDLE;
            default:     arb_next = BPCFG_IDLE;
        endcase
    end

    // Arbiter state register and last-owner memory
    // Last owner kept while idle so rotation survives gaps
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            arb_reg  <= BPCFG_IDLE;
            last_reg <= 2'd0;
        end else begin
            arb_reg <= arb_next;
            if (arb_next == BPCFG_GLAN) begin
                last_reg <= 2'd1;
            end else if (arb_next == BPCFG_GHBI) begin
                last_reg <= 2'd2;
            end else if (arb_next == BPCFG_GPROC) begin
                last_reg <= 2'd0;
            end
        end
    end

    // Grant, ROM enable and transfer strobe
    // Taken from the next state so grant and state agree
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            bp_gnt_o    <= '0;
            bp_rom_en_o <= 1'b0;
            bp_strobe_o <= 1'b0;
        end else begin
            bp_gnt_o    <= {arb_next == BPCFG_GHBI, arb_next == BPCFG_GLAN,
                            arb_next == BPCFG_GPROC};
            bp_rom_en_o <= (arb_next == BPCFG_GPROC) & bp_rom_sel_i;
            bp_strobe_o <= (arb_next != BPCFG_IDLE);
        end
    end

    // Host interface DMA; control preempts data, host slave wins over both
    // Data DMA resumes by itself once the others end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dma_ctrl_act_o       <= 1'b0;
            dma_data_act_o       <= 1'b0;
            dma_block_o          <= 1'b0;
            addr_data_xcvr_dir_o <= 1'b0;
            ctrl_xcvr_dir_o      <= 1'b0;
        end else begin
            dma_ctrl_act_o <= dma_ctrl_req_i & ~host_slave_sel_i;
            dma_data_act_o <= dma_data_req_i & ~dma_ctrl_req_i & ~host_slave_sel_i;
            dma_block_o    <= dma_data_req_i & ~dma_ctrl_req_i & ~host_slave_sel_i;
            addr_data_xcvr_dir_o <= (host_slave_sel_i & host_slave_rd_i)
                                    | (~host_slave_sel_i
                                       & (dma_ctrl_req_i | dma_data_req_i));
            ctrl_xcvr_dir_o <= ~host_slave_sel_i & (dma_ctrl_req_i | dma_data_req_i);
        end
    end

    // Backport DMA word address, counts once per host interface done under grant
    // A reload wins over a count in the same cycle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dma_cnt_reg <= '0;
        end else if (reg_req_i.wr && reg_req_i.addr == BPCFG_OFF_HBREG) begin
            dma_cnt_reg <= reg_req_i.wdata[15:0];
        end else if (arb_reg == BPCFG_GHBI && bp_done_i[BPCFG_REQ_HBI]) begin
            dma_cnt_reg <= dma_cnt_reg + 16'd1;
        end
    end

    // Counter drives the backport address lines directly
    assign bp_dma_addr_o = dma_cnt_reg;

    // Interface controller register, written by processor over backport
    // Its low half also seeds the DMA counter
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hbreg_reg <= '0;
        end else if (reg_req_i.wr && reg_req_i.addr == BPCFG_OFF_HBREG) begin
            hbreg_reg <= reg_req_i.wdata;
        end
    end

    // Read data, one cycle after read strobe; unmapped reads zero
    // Data hold until the next read strobe
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
        end else if (reg_req_i.rd) begin
            if (reg_req_i.addr == BPCFG_OFF_MODE) begin
                reg_rdata_o <= {31'd0, legacy_sw_reg};
            end else if (reg_req_i.addr == BPCFG_OFF_STATUS) begin
                reg_rdata_o <= {27'd0, straps_reg.base_open,
                                is_legacy(straps_reg, legacy_sw_reg), sanity_pu_reg,
                                remote_boot_en_o, net_ops_en_o};
            end else if (reg_req_i.addr == BPCFG_OFF_IRQF) begin
                reg_rdata_o <= {29'd0, bp_gnt_o};
            end else if (reg_req_i.addr == BPCFG_OFF_HBREG) begin
                reg_rdata_o <= hbreg_reg;
            end else if (reg_req_i.addr == BPCFG_OFF_SA_LO) begin
                reg_rdata_o <= {16'd0, BPCFG_SA_DEFAULT[15:0]};
            end else if (reg_req_i.addr == BPCFG_OFF_SA_MID) begin
                // Middle word of the station address
                reg_rdata_o <= {16'd0, BPCFG_SA_DEFAULT[31:16]};
            end else if (reg_req_i.addr == BPCFG_OFF_SA_HI) begin
                reg_rdata_o <= {16'd0, BPCFG_SA_DEFAULT[47:32]};
            end else begin
                reg_rdata_o <= '0;
            end
        end
    end

endmodule

// *** tb/bpcfg_req_model.sv ***
// Backport requester model: three requesters that raise a level request,
// keep it through the grant for a few cycles, then pulse done once.
// Assumes the arbiter answers with a one-hot grant on the same clock.
`timescale 1ns/1ps
module bpcfg_req_model #(
    parameter int HOLD = 3  // Granted cycles counted before the one that raises done
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // Start pulses from the bench, grants from the arbiter
    input  wire logic [2:0] go_i,
    input  wire logic [2:0] gnt_i,
    // Requests and completion pulses
    output logic [2:0]      req_o,
    output logic [2:0]      done_o
);
    int cnt [3];  // Cycles spent under grant

    // Each requester works alone; done is a single-cycle pulse
    // Request held until done
    always_ff @(posedge clock_i) begin
        for (int r = 0; r < 3; r++) begin
            done_o[r] <= 1'b0;
            if (!rst_n_i) begin
                req_o[r] <= 1'b0;
                cnt[r]   <= 0;
            end else if (go_i[r]) begin
                req_o[r] <= 1'b1;
            end else if (req_o[r] && gnt_i[r]) begin
                // Count grant cycles, then release with done
                cnt[r] <= cnt[r] + 1;
                if (cnt[r] == HOLD) begin
                    done_o[r] <= 1'b1;
                    req_o[r]  <= 1'b0;
                    cnt[r]    <= 0;
                end
            end
        end
    end
endmodule

// *** tb/bpcfg_top_asserts.sv ***
// Checker for the backport configuration block, bound to its top module.
// Assumes straps are held steady for several cycles before being judged.
`timescale 1ns/1ps
module bpcfg_top_asserts
    import bpcfg_pkg::*;
(
    // Clock and reset
    input wire logic          clock_i,
    input wire logic          rst_n_i,
    // Observed inputs
    input wire bpcfg_straps_s straps_i,
    input wire logic [2:0]    bp_req_i,
    input wire logic [2:0]    bp_done_i,
    input wire logic          dma_ctrl_req_i,
    input wire logic          host_slave_sel_i,
    // Observed outputs
    input wire logic [2:0]    bp_gnt_o,
    input wire logic          bp_rom_en_o,
    input wire logic          bp_strobe_o,
    input wire logic          dma_ctrl_act_o,
    input wire logic          dma_data_act_o,
    input wire logic          ctrl_xcvr_dir_o,
    input wire logic          addr_data_xcvr_dir_o,
    input wire logic          clk_a_en_o,
    input wire logic          clk_b_en_o,
    input wire logic          lan_clk_o,
    input wire logic          proc_clk_o,
    input wire logic [21:0]   base_addr_o,
    input wire logic          net_ops_en_o,
    input wire logic          legacy_compat_mode_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Clock step sequences
    sequence s_alt;
        (clk_a_en_o && !clk_b_en_o) ##1 (!clk_a_en_o && clk_b_en_o);
    endsequence
    sequence s_proc_hi;
        proc_clk_o [*2];
    endsequence
    sequence s_proc_lo;
        !proc_clk_o [*2];
    endsequence

    property p_gnt_onehot; $onehot0(bp_gnt_o); endproperty
    a_gnt_onehot: assert property (p_gnt_onehot) else $error("two grants at once");
    property p_gnt_hold; bp_gnt_o != 3'b000 && (bp_done_i & bp_gnt_o) == 3'b000 |=> $stable(bp_gnt_o); endproperty
    a_gnt_hold: assert property (p_gnt_hold) else $error("grant moved early");
    property p_gnt_drop; (bp_done_i & bp_gnt_o) != 3'b000 |=> bp_gnt_o == 3'b000; endproperty
    a_gnt_drop: assert property (p_gnt_drop) else $error("grant kept after done");
    property p_gnt_lat; bp_gnt_o == 3'b000 && bp_req_i != 3'b000 |=> bp_gnt_o != 3'b000; endproperty
    a_gnt_lat: assert property (p_gnt_lat) else $error("request not granted");
    property p_rom; bp_rom_en_o |-> bp_gnt_o == 3'b001; endproperty
    a_rom: assert property (p_rom) else $error("ROM enabled without processor");
    property p_strobe; bp_strobe_o == (bp_gnt_o != 3'b000); endproperty
    a_strobe: assert property (p_strobe) else $error("strobe and grant disagree");
    property p_clk_alt; $rose(clk_a_en_o) |-> s_alt ##1 (clk_a_en_o && !clk_b_en_o); endproperty
    a_clk_alt: assert property (p_clk_alt) else $error("enables not alternating");
    property p_proc_clk; $rose(proc_clk_o) |-> s_proc_hi ##1 s_proc_lo ##1 proc_clk_o; endproperty
    a_proc_clk: assert property (p_proc_clk) else $error("processor clock period wrong");
    property p_lan_anti; $rose(lan_clk_o) |-> !proc_clk_o ##2 (proc_clk_o && !lan_clk_o); endproperty
    a_lan_anti: assert property (p_lan_anti) else $error("LAN clock phase wrong");
    property p_base; $stable(straps_i.base_open) [*8] |->
        base_addr_o == (straps_i.base_open ? BPCFG_BASE_UNIT2 : BPCFG_BASE_UNIT1); endproperty
    a_base: assert property (p_base) else $error("base address wrong");
    property p_legacy; straps_i.mode_open [*8] |-> legacy_compat_mode_o && !net_ops_en_o; endproperty
    a_legacy: assert property (p_legacy) else $error("legacy mode not forced");
    property p_xcvr; dma_ctrl_act_o || dma_data_act_o |-> ctrl_xcvr_dir_o && addr_data_xcvr_dir_o; endproperty
    a_xcvr: assert property (p_xcvr) else $error("direction low during DMA");
    property p_dma_lat; dma_ctrl_req_i && !host_slave_sel_i |=> dma_ctrl_act_o && !dma_data_act_o; endproperty
    a_dma_lat: assert property (p_dma_lat) else $error("control DMA not active");
endmodule

bind bpcfg_top bpcfg_top_asserts u_bpcfg_top_asserts (
    .clock_i, .rst_n_i, .straps_i, .bp_req_i, .bp_done_i, .dma_ctrl_req_i, .host_slave_sel_i,
    .bp_gnt_o, .bp_rom_en_o, .bp_strobe_o, .dma_ctrl_act_o, .dma_data_act_o, .ctrl_xcvr_dir_o,
    .addr_data_xcvr_dir_o, .clk_a_en_o, .clk_b_en_o, .lan_clk_o, .proc_clk_o, .base_addr_o,
    .net_ops_en_o, .legacy_compat_mode_o
);

// *** tb/tb.sv ***
// Testbench for the backport configuration block: straps, register port,
// arbiter with the requester model, DMA selection and derived clocks.
`timescale 1ns/1ps
module tb;
    import bpcfg_pkg::*;
    logic           clock_i, rst_n_i, mo, op, proc_q, lan_q;
    bpcfg_straps_s  straps_i;
    bpcfg_reg_req_s reg_req_i;
    logic [31:0]    reg_rdata_o;
    logic [2:0]     bp_req_i, bp_done_i, bp_gnt_o, go, last_gnt;
    logic           bp_rom_sel_i, bp_rom_en_o, bp_strobe_o, dma_ctrl_req_i, dma_data_req_i;
    logic           host_slave_sel_i, host_slave_rd_i, dma_ctrl_act_o, dma_data_act_o;
    logic           dma_block_o, addr_data_xcvr_dir_o, ctrl_xcvr_dir_o, clk_a_en_o, clk_b_en_o;
    logic           lan_clk_o, proc_clk_o, net_ops_en_o, remote_boot_en_o, sanity_auto_o;
    logic           legacy_compat_mode_o;
    logic [15:0]    bp_dma_addr_o;
    logic [21:0]    base_addr_o;
    logic [2:0]     gnt_q [$];                                // Grants in order seen
    logic [2:0]     exp_gnt [3] = '{3'b100, 3'b010, 3'b001};  // Host, LAN, processor
    logic [3:0]     dma_in [5] = '{4'b0001, 4'b0011, 4'b1111, 4'b1000, 4'b0000};
    logic [4:0]     dma_exp [5] = '{5'b01111, 5'b10011, 5'b00001, 5'b00000, 5'b00000};
    int             mismatches, n_compared, n_proc, n_lan, n_a;

    bpcfg_top u_bpcfg_top (.*);
    bpcfg_req_model u_bpcfg_req_model (.clock_i, .rst_n_i, .go_i(go), .gnt_i(bp_gnt_o),
                                       .req_o(bp_req_i), .done_o(bp_done_i));

    // Clock at 25 ns
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // Grant order, ROM enable and clock edge counts
    always @(posedge clock_i) begin
        if (bp_gnt_o !== last_gnt && bp_gnt_o !== 3'b000)
            gnt_q.push_back(bp_gnt_o);
        if (bp_gnt_o === 3'b001)
            check({31'h0, bp_rom_en_o}, 32'h0000_0001);
        if (proc_clk_o && !proc_q)
            n_proc++;
        if (lan_clk_o && !lan_q)
            n_lan++;
        if (clk_a_en_o)
            n_a++;
        proc_q   <= proc_clk_o;
        lan_q    <= lan_clk_o;
        last_gnt <= bp_gnt_o;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Wait n edges, then step off the edge so outputs are settled
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic do_reset();
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        reg_req_i.wr <= 1'b0;
    endtask
    // Read data are taken in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clock_i);
        reg_req_i <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        reg_req_i.rd <= 1'b0;
        #1;
        check(reg_rdata_o & m, e);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog far beyond the expected few hundred cycles
    initial begin
        #100_000;
        mismatches++;
        final_report();
    end

    initial begin
        rst_n_i = 1'b0;
        straps_i = '0;
        reg_req_i = '0;
        go = 3'b000;
        {bp_rom_sel_i, dma_ctrl_req_i, dma_data_req_i, host_slave_sel_i, host_slave_rd_i} = '0;
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        // All four mode/option combinations, base open when they differ, each from a fresh reset
        for (int i = 0; i < 4; i++) begin
            mo = i[1];
            op = i[0];
            @(posedge clock_i);
            straps_i <= '{base_open: mo ^ op, mode_open: mo, option_open: op};
            do_reset();
            tick(12);
            check(32'(base_addr_o), 32'((mo ^ op) ? BPCFG_BASE_UNIT2 : BPCFG_BASE_UNIT1));
            check({28'h0, net_ops_en_o, remote_boot_en_o, legacy_compat_mode_o, sanity_auto_o},
                  {28'h0, !mo, !mo && op, mo, mo && op});
            rd_chk(BPCFG_OFF_STATUS, 32'h0000_001F,
                   {27'h0, mo ^ op, mo, mo && op, !mo && op, !mo});
        end
        $display("test straps done");
        // Legacy select written while refused, then switch closed
        reg_wr(BPCFG_OFF_MODE, 32'h0000_0001);
        straps_i <= '{base_open: 1'b0, mode_open: 1'b0, option_open: 1'b1};
        tick(12);
        check({30'h0, legacy_compat_mode_o, net_ops_en_o}, 32'h0000_0001);
        reg_wr(BPCFG_OFF_MODE, 32'h0000_0001);
        reg_wr(8'h3C, 32'h0000_0000);
        tick(3);
        check({30'h0, legacy_compat_mode_o, net_ops_en_o}, 32'h0000_0002);
        reg_wr(BPCFG_OFF_MODE, 32'h0000_0000);
        tick(3);
        check({30'h0, legacy_compat_mode_o, net_ops_en_o}, 32'h0000_0001);
        $display("test mode select done");
        // Station address is fixed and ignores writes
        reg_wr(BPCFG_OFF_SA_LO, 32'h0000_5A5A);
        rd_chk(BPCFG_OFF_SA_LO, 32'h0000_FFFF, {16'h0, BPCFG_SA_DEFAULT[15:0]});
        rd_chk(BPCFG_OFF_SA_MID, 32'h0000_FFFF, {16'h0, BPCFG_SA_DEFAULT[31:16]});
        rd_chk(BPCFG_OFF_SA_HI, 32'h0000_FFFF, {16'h0, BPCFG_SA_DEFAULT[47:32]});
        reg_wr(BPCFG_OFF_HBREG, 32'h1234_ABCD);
        tick(1);
        check({16'h0, bp_dma_addr_o}, 32'h0000_ABCD);
        rd_chk(BPCFG_OFF_HBREG, 32'hFFFF_FFFF, 32'h1234_ABCD);
        $display("test registers done");
        // All three request together, ROM selected throughout
        @(posedge clock_i);
        bp_rom_sel_i <= 1'b1;
        go <= 3'b111;
        @(posedge clock_i);
        go <= 3'b000;
        tick(40);
        check(gnt_q.size(), 3);
        foreach (exp_gnt[k])
            check({29'h0, gnt_q[k]}, {29'h0, exp_gnt[k]});
        check({16'h0, bp_dma_addr_o}, 32'h0000_ABCE);
        rd_chk(BPCFG_OFF_IRQF, 32'h0000_0007, 32'h0000_0000);
        $display("test arbiter done");
        // DMA and slave priorities with transceiver directions
        foreach (dma_in[k]) begin
            @(posedge clock_i);
            {host_slave_sel_i, host_slave_rd_i, dma_ctrl_req_i, dma_data_req_i} <= dma_in[k];
            tick(3);
            check({27'h0, dma_ctrl_act_o, dma_data_act_o, dma_block_o, ctrl_xcvr_dir_o,
                   addr_data_xcvr_dir_o}, {27'h0, dma_exp[k]});
        end
        $display("test dma done");
        // Derived clock rates over forty oscillator cycles
        {n_proc, n_lan, n_a} = '0;
        tick(40);
        check(32'(n_proc), 32'h0000_000A);
        check(32'(n_lan), 32'h0000_000A);
        check(32'(n_a), 32'h0000_0014);
        $display("test clocks done");
        final_report();
    end
endmodule
